/* File: verilog/amc_pkg.sv */
/*
   Package for the mode configuration register block: field positions,
   reset values, encodings and timing of the conversion-ready pin.
   Assumes a single 10 MHz clock and an active-low asynchronous reset.
*/
package amc_pkg;
   localparam int              REG_W          = 16;
   localparam int              RST_FLAG_BIT   = 10;
   localparam int              WLEN_HI        = 9;
   localparam int              WLEN_LO        = 8;
   localparam int              RSVD_HI        = 7;
   localparam int              RSVD_LO        = 5;
   localparam int              TIMEOUT_BIT    = 4;
   localparam int              RSRC_HI        = 3;
   localparam int              RSRC_LO        = 2;
   localparam int              FLOAT_BIT      = 1;
   localparam int              PULSE_BIT      = 0;
   localparam logic [15:0]     MODE_RESET     = 16'h0510;
   localparam logic [15:0]     MODE_WMASK     = 16'h07ff;
   localparam logic [1:0]      WLEN_16        = 2'h0;
   localparam logic [1:0]      WLEN_24        = 2'h1;
   localparam logic [1:0]      WLEN_32_ZERO   = 2'h2;
   localparam logic [1:0]      WLEN_32_SIGN   = 2'h3;
   localparam logic [1:0]      RSRC_LAG       = 2'h0;
   localparam logic [1:0]      RSRC_OR        = 2'h1;
   localparam int              CLK_HZ         = 10_000_000;
   localparam int              PULSE_NS       = 200;
   localparam int              PULSE_CYC      = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   typedef enum logic [1:0] {AMC_W16, AMC_W24, AMC_W32} amc_width_type;
endpackage : amc_pkg

/* File: verilog/amc_fmt_if.sv */
/*
   Carrier between the register block and the word formatter.
   Assumes both ends share the block's clock.
*/
interface amc_fmt_if;
   logic [1:0]  word_width_sel;
   logic [23:0] result;
   logic [31:0] word;
   logic [5:0]  word_bits;
   modport regs (output word_width_sel, output result, input word, input word_bits);
   modport fmt  (input word_width_sel, input result, output word, output word_bits);
endinterface : amc_fmt_if

/* File: verilog/amc_word_fmt.sv */
/*
   Data word formatter: shapes a 24-bit result to the chosen word width.
   Assumes the result is stable while the word is read; output is registered.
*/
module amc_word_fmt
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   amc_fmt_if.fmt        f
);
   import amc_pkg::*;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         f.word      <= 32'h0000_0000;
         f.word_bits <= 6'h18;
      end
      else
      begin
         case (f.word_width_sel)
            WLEN_16:
            begin
               f.word      <= {16'h0000, f.result[23:8]};
               f.word_bits <= 6'h10;
            end
            WLEN_24:
            begin
               f.word      <= {8'h00, f.result};
               f.word_bits <= 6'h18;
            end
            WLEN_32_ZERO:
            begin
               f.word      <= {f.result, 8'h00};
               f.word_bits <= 6'h20;
            end
            default:
            begin
               f.word      <= {{8{f.result[23]}}, f.result};
               f.word_bits <= 6'h20;
            end
         endcase
      end
   end
endmodule : amc_word_fmt

/* File: verilog/amc_mode_regs.sv */
/*
   Mode configuration register (low half) with conversion-ready pin driver
   and data word shaping. Register reached by a plain write/read port
   driven by the serial interface decoder. Channel ready levels arrive as
   one-cycle pulses per channel, synchronous to ref_clk.
*/
module amc_mode_regs
#(
   parameter int NCH = 8
)
(
   input  wire logic                ref_clk,
   input  wire logic                rstn,
   input  wire logic                reg_wr_en,
   input  wire logic [15:0]         reg_wr_data,
   output logic [15:0]              reg_rd_data,
   input  wire logic [NCH-1:0]      ch_enable,
   input  wire logic [NCH-1:0]      ch_ready,
   input  wire logic                data_read,
   input  wire logic [23:0]         conv_result,
   output logic [31:0]              data_word,
   output logic [5:0]               data_word_bits,
   output logic                     spi_timeout_en,
   output logic                     conversion_ready_pin_o,
   output logic                     conversion_ready_pin_oe
);
   import amc_pkg::*;

   logic [15:0]      mode_r;
   logic [NCH-1:0]   seen_r;
   logic             avail_r;
   logic [7:0]       pulse_cnt_r;
   logic             pulse_r;
   logic [NCH-1:0]   en_ready;
   logic [NCH-1:0]   seen_nxt;
   logic             event_now;
   amc_fmt_if        fmt_bus ();

   // Register: reset sets flag and defaults, writes store bits 9:0 and clear bits 15:11
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         mode_r <= MODE_RESET;
      else if (reg_wr_en)
      begin
         mode_r               <= reg_wr_data & MODE_WMASK;
         mode_r[RST_FLAG_BIT] <= reg_wr_data[RST_FLAG_BIT] & mode_r[RST_FLAG_BIT];
      end
   end

   // Flag can only be cleared by writing 0; writing 1 keeps it unchanged
   assign reg_rd_data    = mode_r;
   assign spi_timeout_en = mode_r[TIMEOUT_BIT];

   assign en_ready = ch_ready & ch_enable;
   assign seen_nxt = seen_r | en_ready;

   // Data-ready event per source selection
   always_comb
   begin
      case (mode_r[RSRC_HI:RSRC_LO])
         RSRC_LAG: event_now = (ch_enable != '0) && ((seen_nxt & ch_enable) == ch_enable);
         RSRC_OR:  event_now = |en_ready;
         default:  event_now = (seen_r == '0) && (|en_ready);
      endcase
   end

   // Tracks which enabled channels have reported this conversion round
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         seen_r <= '0;
      else if (event_now && mode_r[RSRC_HI:RSRC_LO] == RSRC_LAG)
         seen_r <= '0;
      else if ((seen_nxt & ch_enable) == ch_enable)
         seen_r <= '0;
      else
         seen_r <= seen_nxt & ch_enable;
   end

   // Data available until read; new event wins over read
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         avail_r <= 1'b0;
      else if (event_now)
         avail_r <= 1'b1;
      else if (data_read)
         avail_r <= 1'b0;
   end

   // Fixed-length low pulse
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pulse_cnt_r <= 8'h00;
         pulse_r     <= 1'b0;
      end
      else if (event_now)
      begin
         pulse_cnt_r <= 8'(PULSE_CYC - 1);
         pulse_r     <= 1'b1;
      end
      else if (pulse_cnt_r != 8'h00)
         pulse_cnt_r <= pulse_cnt_r - 8'h01;
      else
         pulse_r     <= 1'b0;
   end

   // Pin: low when active, else idle high or floating
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         conversion_ready_pin_o  <= 1'b1;
         conversion_ready_pin_oe <= 1'b1;
      end
      else if (mode_r[PULSE_BIT] ? pulse_r : avail_r)
      begin
         conversion_ready_pin_o  <= 1'b0;
         conversion_ready_pin_oe <= 1'b1;
      end
      else
      begin
         conversion_ready_pin_o  <= 1'b1;
         conversion_ready_pin_oe <= ~mode_r[FLOAT_BIT];
      end
   end

   assign fmt_bus.word_width_sel = mode_r[WLEN_HI:WLEN_LO];
   assign fmt_bus.result         = conv_result;
   assign data_word              = fmt_bus.word;
   assign data_word_bits         = fmt_bus.word_bits;

   amc_word_fmt u_fmt
   (
      .clk   (ref_clk),
      .rst_n (rstn),
      .f     (fmt_bus.fmt)
   );
endmodule : amc_mode_regs

/* File: testbench/amc_mode_regs_asserts.sv */
/* Port checker for amc_mode_regs.
   Bound to every instance; single clock, async low reset. */
module amc_mode_regs_asserts #(parameter int NCH = 8)
(
   input wire logic            ref_clk,
   input wire logic            rstn,
   input wire logic            reg_wr_en,
   input wire logic [15:0]     reg_wr_data,
   input wire logic [15:0]     reg_rd_data,
   input wire logic [NCH-1:0]  ch_enable,
   input wire logic [NCH-1:0]  ch_ready,
   input wire logic            data_read,
   input wire logic [23:0]     conv_result,
   input wire logic [31:0]     data_word,
   input wire logic [5:0]      data_word_bits,
   input wire logic            spi_timeout_en,
   input wire logic            conversion_ready_pin_o,
   input wire logic            conversion_ready_pin_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   reset_val_a: assert property ($rose(rstn) |-> reg_rd_data == 16'h0510)
      else $error("bad reset value");
   write_back_a: assert property (reg_wr_en |=> reg_rd_data[9:0] == $past(reg_wr_data[9:0])
      && reg_rd_data[15:11] == 5'h00 && reg_rd_data[10] <= $past(reg_wr_data[10]))
      else $error("bad write back");
   tmo_track_a: assert property (spi_timeout_en == reg_rd_data[4]) else $error("bad timeout");
   width_bits_a: assert property (!reg_rd_data[9] |=> data_word_bits ==
      ($past(reg_rd_data[8]) ? 6'h18 : 6'h10)) else $error("bad width");
   pad_zero_a: assert property (reg_rd_data[9:8] == 2'h2 |=>
      data_word == {$past(conv_result), 8'h00}) else $error("bad zero pad");
   sign_ext_a: assert property (reg_rd_data[9:8] == 2'h3 |=>
      data_word == {{8{$past(conv_result[23])}}, $past(conv_result)}) else $error("bad sign");
   or_source_a: assert property (reg_rd_data[3:2] == 2'h1 && |(ch_ready & ch_enable)
      |-> ##2 !conversion_ready_pin_o) else $error("bad or source");
   pulse_len_a: assert property ($fell(conversion_ready_pin_o) && reg_rd_data[0] |->
      !conversion_ready_pin_o[*2] ##1 conversion_ready_pin_o) else $error("bad pulse");
   hold_low_a: assert property (!conversion_ready_pin_o && !reg_rd_data[0] && !data_read
      && !reg_wr_en && !$past(data_read) && !$past(reg_wr_en) |=> !conversion_ready_pin_o)
      else $error("bad hold");
   idle_oe_a: assert property (conversion_ready_pin_o && $stable(reg_rd_data[1]) |->
      conversion_ready_pin_oe == !reg_rd_data[1]) else $error("bad idle");
endmodule : amc_mode_regs_asserts
bind amc_mode_regs amc_mode_regs_asserts #(.NCH(NCH)) chk_u (.ref_clk, .rstn, .reg_wr_en,
   .reg_wr_data, .reg_rd_data, .ch_enable, .ch_ready, .data_read, .conv_result, .data_word,
   .data_word_bits, .spi_timeout_en, .conversion_ready_pin_o, .conversion_ready_pin_oe);

/* File: testbench/amc_chan_model.sv */
/* Channel ready source: channel i reports at phase 4*i of 32.
   Assumes the block's clock and reset. */
module amc_chan_model
(
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] ch_enable,
   output logic      [4:0] phase_r,
   output logic      [7:0] ch_ready
);
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
         phase_r <= 5'h00;
      else
         phase_r <= phase_r + 5'h01;
   always_comb
      for (int i = 0; i < 8; i++)
         ch_ready[i] = ch_enable[i] && phase_r == 5'(4 * i);
endmodule : amc_chan_model

/* File: testbench/amc_mode_regs_bench.sv */
/* Bench for amc_mode_regs: register, word shaping, ready pin.
   Assumes amc_chan_model supplies the channel pulses. */
module amc_mode_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr_en = 1'b0, data_read = 1'b0;
   logic [15:0] reg_wr_data = 16'h0000, reg_rd_data;
   logic [7:0]  ch_enable = 8'h0e, ch_ready;
   logic [23:0] conv_result = 24'h801234;
   logic [31:0] data_word;
   logic [31:0] wexp [4] = '{32'h00008012, 32'h00801234, 32'h80123400, 32'hff801234};
   logic [5:0]  data_word_bits;
   logic [4:0]  phase_r;
   logic        tmo_en, pin_o, pin_oe;
   int          fails = 0, cmp_count = 0, cyc = 0;
   initial forever #50 ref_clk = ~ref_clk;
   amc_mode_regs #(.NCH(8)) dut_u (.ref_clk, .rstn, .reg_wr_en, .reg_wr_data, .reg_rd_data,
      .ch_enable, .ch_ready, .data_read, .conv_result, .data_word, .data_word_bits,
      .spi_timeout_en(tmo_en), .conversion_ready_pin_o(pin_o), .conversion_ready_pin_oe(pin_oe));
   amc_chan_model src_u (.ref_clk, .rstn, .ch_enable, .phase_r, .ch_ready);
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   always @(posedge ref_clk)
      if (++cyc == 2000)
      begin
         fails++;
         close_out();
      end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge ref_clk) #1;
   endtask : tick
   task automatic wr(input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr_en <= 1'b1;
      reg_wr_data <= d & 16'hff1f;
      tick();
      reg_wr_en <= 1'b0;
   endtask : wr
   // Pulse mode, floating idle; count falls over one round
   task automatic run_src(input logic [1:0] sel, input int exp_n, input int lo);
      logic prev;
      int   n, first;
      wr(16'h0113 | {12'h000, sel, 2'h0});
      while (phase_r !== 5'h1f) tick();
      n = 0;
      first = 99;
      prev = pin_o;
      repeat (32)
      begin
         tick();
         if (prev && !pin_o && first == 99)
            first = phase_r;
         n += int'(prev && !pin_o);
         prev = pin_o;
      end
      chk(n, exp_n);
      chk(first >= lo && first <= lo + 2, 1);
   endtask : run_src
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      tick();
      chk(reg_rd_data, 16'h0510);
      chk(tmo_en, 1);
      while (phase_r !== 5'h10) tick();
      chk({pin_o, pin_oe}, 2'b01);
      data_read <= 1'b1;
      tick();
      data_read <= 1'b0;
      repeat (2) tick();
      chk({pin_o, pin_oe}, 2'b11);
      $display("test reset and hold done");
      wr(16'hf80e);
      chk(reg_rd_data, 16'h000e);
      chk(tmo_en, 0);
      wr(16'h040e);
      chk(reg_rd_data, 16'h000e);
      rstn <= 1'b0;
      tick();
      rstn <= 1'b1;
      tick();
      chk(reg_rd_data, 16'h0510);
      for (int w = 0; w < 4; w++)
      begin
         wr(16'h0010 | 16'(w << 8));
         tick();
         chk(data_word_bits, w == 0 ? 16 : w == 1 ? 24 : 32);
         chk(data_word, wexp[w]);
      end
      $display("test register and width done");
      run_src(2'h1, 3, 5);
      run_src(2'h2, 1, 5);
      run_src(2'h3, 1, 5);
      run_src(2'h0, 1, 13);
      $display("test ready source done");
      close_out();
   end
endmodule : amc_mode_regs_bench
